/* File: design/flash_cmd_front_end.sv */
// serial flash command front end: shifter on the serial clock, decode on sys_clk
// assumes host-driven serial clock, frames closed by select; core reports busy
`timescale 1ns/1ns
module flash_cmd_front_end (
    // system
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // serial link
    input  wire logic                      link_clk,
    input  wire logic                      sel_n,
    input  wire logic                      data_in,
    output logic                           data_out,
    output logic                           data_out_en,
    // core side
    input  wire logic                      core_busy,
    input  wire logic [7:0]                param_byte,
    output flash_cmd_pkg::array_req_t      array_req,
    output logic                           quad_mode,
    output logic                           addr4_mode,
    output logic                           sleeping,
    output logic [7:0]                     status1,
    output logic [7:0]                     status2,
    output logic [7:0]                     status3,
    output logic [7:0]                     ext_addr
);
    import flash_cmd_pkg::*;

    // link domain state
    typedef struct packed {
        logic [2:0]  bitn;
        logic [5:0]  nbytes;
        logic [7:0]  shreg;
        logic [7:0]  opcode;
        logic [ADDR_W-1:0] addr;
        logic [7:0]  d0;
        logic [7:0]  d1;
        logic [7:0]  d2;
        logic        active;
    } link_st_t;

    // falling-edge output side of the link
    typedef struct packed {
        logic [7:0]  obyte;
        logic        alt;
        logic        dout;
    } link_out_t;

    typedef struct packed {
        logic [1:0]  sel_sync;
        logic [1:0]  busy_sync;
        logic        frame;
        logic        wl;
        logic        vol_wl;
        logic        reset_armed;
        logic        quad;
        logic        addr4;
        logic        sleep;
        logic [7:0]  sr1;
        logic [7:0]  sr2;
        logic [7:0]  sr3;
        logic [7:0]  xaddr;
        array_req_t  req;
    } sys_st_t;

    link_st_t  ls, next_ls, cur;
    link_out_t lo;
    sys_st_t  ss, next_ss;
    frame_t   done;
    logic     sel_q;

    // select only ends a frame; fields stay for the system side to read
    // limitation: a select pulse with no clocks replays the last frame
    // msb first capture
    always_comb begin
        cur = ls;
        // first clock of a frame starts from cleared counters
        if (!ls.active) begin
            cur.bitn   = 3'h0;
            cur.nbytes = 6'h00;
            cur.opcode = 8'h00;
            cur.addr   = '0;
            cur.d0     = 8'h00;
            cur.d1     = 8'h00;
            cur.d2     = 8'h00;
        end
        next_ls        = cur;
        next_ls.active = 1'b1;
        next_ls.shreg  = {cur.shreg[6:0], data_in};
        next_ls.bitn   = cur.bitn + 3'h1;
        if (cur.bitn == BIT_LAST) begin
            if (cur.nbytes != BYTES_SAT)
                next_ls.nbytes = cur.nbytes + 6'h01;
            unique case (cur.nbytes)
                6'h00:   next_ls.opcode = {cur.shreg[6:0], data_in};
                6'h01:   next_ls.d0 = {cur.shreg[6:0], data_in};
                6'h02:   next_ls.d1 = {cur.shreg[6:0], data_in};
                6'h03:   next_ls.d2 = {cur.shreg[6:0], data_in};
                default: ;
            endcase
            if (cur.nbytes >= 6'h01 && cur.nbytes <= BYTES_ADDR4)
                next_ls.addr = {cur.addr[ADDR_W-9:0], cur.shreg[6:0], data_in};
        end
    end

    // output byte for the read stream, chosen per byte boundary
    // data-out phase for read opcodes
    function automatic logic [7:0] out_byte(input logic [7:0] op, input logic [5:0] n,
                                            input logic alt, input logic [7:0] sel);
        logic [7:0] b;
        b = 8'h00;
        unique case (op)
            OP_SR1_READ:                   b = ss.sr1;
            OP_SR2_READ_A, OP_SR2_READ_B:  b = ss.sr2;
            OP_SR3_READ_A, OP_SR3_READ_B:  b = ss.sr3;
            OP_XADDR_READ:                 b = ss.xaddr;
            OP_WAKE_ID:                    b = PART_CODE_BYTE;
            OP_MFR_ID_A, OP_MFR_ID_B, OP_MFR_ID_C:
                b = ((sel == 8'h01) ^ alt) ? PART_CODE_BYTE : MFR_CODE_BYTE;
            OP_JEDEC_ID: begin
                if (n == 6'h01)
                    b = MFR_CODE_BYTE;
                else if (n == 6'h02)
                    b = MEM_TYPE_BYTE;
                else if (n == 6'h03)
                    b = MEM_CAP_BYTE;
            end
            OP_PARAM_READ:                 b = param_byte;
            default:                       b = 8'h00;
        endcase
        return b;
    endfunction

    function automatic logic out_phase(input logic [7:0] op, input logic [5:0] n);
        logic r;
        r = 1'b0;
        unique case (op)
            OP_SR1_READ, OP_SR2_READ_A, OP_SR2_READ_B, OP_SR3_READ_A,
            OP_SR3_READ_B, OP_XADDR_READ, OP_JEDEC_ID: r = (n >= 6'h01);
            OP_WAKE_ID:    r = (n >= 6'h01 + BYTES_WAKE_DUMMY);
            OP_MFR_ID_A, OP_MFR_ID_B, OP_MFR_ID_C: r = (n >= 6'h01 + BYTES_MFR_SEL);
            OP_PARAM_READ: r = (n >= 6'h01 + BYTES_PARAM_HDR);
            default:       r = 1'b0;
        endcase
        return r;
    endfunction

    // shifter on rising link clock; deselect only drops the frame flag
    always_ff @(posedge link_clk or posedge sel_n) begin
        if (sel_n) begin
            ls.active <= 1'b0;
        end else begin
            ls <= next_ls;
        end
    end

    // output launched on falling edge so host samples it on the next rise
    // status bytes change only between frames apart from the busy bit, so read here unsynchronised
    always_ff @(negedge link_clk or posedge sel_n) begin
        if (sel_n) begin
            lo.obyte <= 8'h00;
            lo.alt   <= 1'b0;
            lo.dout  <= 1'b0;
        end else if (ls.bitn == 3'h0 && out_phase(ls.opcode, ls.nbytes)) begin
            lo.obyte <= out_byte(ls.opcode, ls.nbytes, lo.alt, ls.d2);
            lo.alt   <= ~lo.alt;
            lo.dout  <= 1'b1;
        end else begin
            lo.obyte <= {lo.obyte[6:0], 1'b0};
            lo.alt   <= lo.alt;
            lo.dout  <= lo.dout;
        end
    end

    // both straight from the falling-edge flops
    always_comb begin
        data_out    = lo.obyte[7];
        data_out_en = lo.dout;
    end

    // frame fields are stable while select is high; sampled only after sync
    always_comb begin
        done.opcode  = ls.opcode;
        done.nbytes  = ls.nbytes;
        done.aligned = (ls.bitn == 3'h0);
        done.addr    = ls.addr;
        done.d0      = ls.d0;
        done.d1      = ls.d1;
        done.d2      = ls.d2;
    end

    // protected region decode
    logic [5:0]  prot_bits;
    logic [9:0]  blk_lo, blk_hi;
    logic        prot_none;
    logic [9:0]  span;
    always_comb begin
        prot_bits = {ss.sr2[SR2_CMP_POS], ss.sr1[SR1_TB_POS], ss.sr1[SR1_BP_LO_POS+3 -: 4]};
        span      = (prot_bits[3:0] == 4'h0) ? 10'h000 :
                    (prot_bits[3:0] >= 4'hb) ? 10'h3ff : 10'((11'h1 << (prot_bits[3:0] - 4'h1)) - 11'h1);
        prot_none = 1'b0;
        blk_lo    = 10'h000;
        blk_hi    = 10'h3ff;
        unique case (prot_bits[5:4])
            2'b00: begin
                prot_none = (prot_bits[3:0] == 4'h0);
                blk_lo    = 10'h3ff - span;
            end
            2'b01: begin
                prot_none = (prot_bits[3:0] == 4'h0);
                blk_hi    = span;
            end
            2'b10: begin
                prot_none = (prot_bits[3:0] >= 4'hb);
                blk_hi    = (prot_bits[3:0] == 4'h0) ? 10'h3ff : 10'h3fe - span;
            end
            2'b11: begin
                prot_none = (prot_bits[3:0] >= 4'hb);
                blk_lo    = (prot_bits[3:0] == 4'h0) ? 10'h000 : span + 10'h001;
            end
        endcase
    end

    logic [9:0]        tgt_blk;
    logic              tgt_prot;
    logic [5:0]        addr_len;
    logic              frame_end;
    logic [ADDR_W-1:0] frame_addr;
    always_comb begin
        addr_len   = ss.addr4 ? BYTES_ADDR4 : BYTES_ADDR3;
        // three-byte program frames shift one data byte into the address
        frame_addr = (ss.addr4 || done.nbytes <= BYTES_ADDR4) ? done.addr :
                     {8'h00, done.addr[ADDR_W-1:8]};
        tgt_blk    = ss.addr4 ? frame_addr[BLOCK_LSB+9:BLOCK_LSB] :
                                {2'b00, frame_addr[BLOCK_LSB+7:BLOCK_LSB]};
        tgt_prot   = ~prot_none && tgt_blk >= blk_lo && tgt_blk <= blk_hi;
        // select high now, open on the previous cycle: one pulse per frame
        frame_end  = ss.sel_sync[1] & ss.frame;
    end

    // command execution on the frame's closing edge
    always_comb begin
        next_ss = ss;
        next_ss.sel_sync  = {ss.sel_sync[0], sel_n};
        next_ss.busy_sync = {ss.busy_sync[0], core_busy};
        next_ss.frame     = ~ss.sel_sync[1];
        next_ss.req.valid = 1'b0;
        // busy mirrors core state
        next_ss.sr1[SR1_BUSY_POS] = ss.busy_sync[1];
        if (frame_end && done.nbytes != 6'h00) begin
            // any other command drops the arm
            next_ss.reset_armed = 1'b0;
            next_ss.vol_wl      = 1'b0;
            if (!ss.sleep || done.opcode == OP_WAKE_ID) begin
                unique case (done.opcode)
                    OP_RESET_ARM:  next_ss.reset_armed = done.aligned;
                    OP_RESET: if (ss.reset_armed && done.aligned) begin
                        next_ss.sr1 = SR_RESET_VALUE;
                        next_ss.sr2 = SR_RESET_VALUE;
                        next_ss.sr3 = SR_RESET_VALUE;
                        next_ss.wl  = 1'b0;
                        next_ss.addr4 = 1'b0;
                        next_ss.quad  = 1'b0;
                    end
                    OP_QUAD_ENTER: if (done.aligned) next_ss.quad = 1'b1;
                    OP_QUAD_LEAVE: next_ss.quad = 1'b0;
                    OP_WL_SET:     if (done.aligned) next_ss.wl = 1'b1;
                    OP_WL_CLEAR:   if (done.aligned) next_ss.wl = 1'b0;
                    OP_VOL_WL_SET: if (done.aligned) next_ss.vol_wl = 1'b1;
                    OP_SR_WRITE: if (done.aligned && (ss.wl || ss.vol_wl) && !ss.busy_sync[1]
                                     && done.nbytes >= 6'h02) begin
                        next_ss.sr1 = {done.d0[7:2], ss.sr1[1:0]};
                        if (done.nbytes >= 6'h03)
                            next_ss.sr2 = done.d1;
                        if (done.nbytes >= 6'h04)
                            next_ss.sr3 = done.d2;
                        next_ss.wl = 1'b0;
                    end
                    OP_SR2_WRITE: if (done.aligned && (ss.wl || ss.vol_wl) && !ss.busy_sync[1]
                                      && done.nbytes == 6'h02) begin
                        next_ss.sr2 = done.d0;
                        next_ss.wl  = 1'b0;
                    end
                    OP_SR3_WRITE_A, OP_SR3_WRITE_B:
                        if (done.aligned && (ss.wl || ss.vol_wl) && !ss.busy_sync[1]
                            && done.nbytes == 6'h02) begin
                            next_ss.sr3 = done.d0;
                            next_ss.wl  = 1'b0;
                        end
                    OP_SLEEP:   if (done.aligned) next_ss.sleep = 1'b1;
                    OP_WAKE_ID: if (done.nbytes >= 6'h01 + BYTES_WAKE_DUMMY) next_ss.sleep = 1'b0;
                    OP_XADDR_WRITE: if (done.aligned && done.nbytes == 6'h02) next_ss.xaddr = done.d0;
                    OP_ADDR4_ENTER: if (done.aligned) next_ss.addr4 = 1'b1;
                    OP_ADDR4_LEAVE: if (done.aligned) next_ss.addr4 = 1'b0;
                    OP_PAGE_WRITE, OP_QPAGE_WRITE:
                        if (done.aligned && ss.wl && !ss.busy_sync[1]
                            && done.nbytes >= addr_len + 6'h02
                            && done.nbytes >= BYTES_PAGE_MIN && !tgt_prot) begin
                            next_ss.req = '{1'b1, KIND_PAGE, frame_addr};
                            next_ss.wl  = 1'b0;
                        end
                    OP_SECTOR_CLEAR, OP_HALF_CLEAR, OP_BLOCK_CLEAR:
                        if (done.aligned && ss.wl && !ss.busy_sync[1]
                            && done.nbytes == addr_len + 6'h01 && !tgt_prot) begin
                            next_ss.req.valid = 1'b1;
                            next_ss.req.addr  = frame_addr;
                            next_ss.req.kind  = (done.opcode == OP_SECTOR_CLEAR) ? KIND_SECTOR :
                                                (done.opcode == OP_HALF_CLEAR) ? KIND_HALF :
                                                KIND_BLOCK;
                            next_ss.wl = 1'b0;
                        end
                    default: ;
                endcase
            end
        end
        next_ss.sr1[SR1_WL_POS] = next_ss.wl;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ss <= '{sel_sync: 2'b11, busy_sync: 2'b00, frame: 1'b0, wl: 1'b0,
                    vol_wl: 1'b0, reset_armed: 1'b0, quad: 1'b0, addr4: 1'b0,
                    sleep: 1'b0, sr1: SR_RESET_VALUE, sr2: SR_RESET_VALUE,
                    sr3: SR_RESET_VALUE, xaddr: 8'h00, req: '0};
        end else begin
            ss <= next_ss;
        end
    end

    always_comb begin
        array_req  = ss.req;
        quad_mode  = ss.quad;
        addr4_mode = ss.addr4;
        sleeping   = ss.sleep;
        status1    = ss.sr1;
        status2    = ss.sr2;
        status3    = ss.sr3;
        ext_addr   = ss.xaddr;
    end

endmodule : flash_cmd_front_end

/* File: design/flash_cmd_pkg.sv */
// shared constants and carriers for the serial flash command front end
// assumes one system clock domain plus the host-driven serial clock
package flash_cmd_pkg;

    // opcodes
    localparam logic [7:0] OP_RESET_ARM    = 8'h66;
    localparam logic [7:0] OP_RESET        = 8'h99;
    localparam logic [7:0] OP_QUAD_ENTER   = 8'h38;
    localparam logic [7:0] OP_QUAD_LEAVE   = 8'hff;
    localparam logic [7:0] OP_WL_SET       = 8'h06;
    localparam logic [7:0] OP_VOL_WL_SET   = 8'h50;
    localparam logic [7:0] OP_WL_CLEAR     = 8'h04;
    localparam logic [7:0] OP_SR1_READ     = 8'h05;
    localparam logic [7:0] OP_SR2_READ_A   = 8'h09;
    localparam logic [7:0] OP_SR2_READ_B   = 8'h35;
    localparam logic [7:0] OP_SR3_READ_A   = 8'h95;
    localparam logic [7:0] OP_SR3_READ_B   = 8'h15;
    localparam logic [7:0] OP_SR_WRITE     = 8'h01;
    localparam logic [7:0] OP_SR2_WRITE    = 8'h31;
    localparam logic [7:0] OP_SR3_WRITE_A  = 8'hc0;
    localparam logic [7:0] OP_SR3_WRITE_B  = 8'h11;
    localparam logic [7:0] OP_SLEEP        = 8'hb9;
    localparam logic [7:0] OP_WAKE_ID      = 8'hab;
    localparam logic [7:0] OP_MFR_ID_A     = 8'h90;
    localparam logic [7:0] OP_MFR_ID_B     = 8'h92;
    localparam logic [7:0] OP_MFR_ID_C     = 8'h94;
    localparam logic [7:0] OP_JEDEC_ID     = 8'h9f;
    localparam logic [7:0] OP_PARAM_READ   = 8'h5a;
    localparam logic [7:0] OP_XADDR_READ   = 8'hc8;
    localparam logic [7:0] OP_XADDR_WRITE  = 8'hc5;
    localparam logic [7:0] OP_ADDR4_ENTER  = 8'hb7;
    localparam logic [7:0] OP_ADDR4_LEAVE  = 8'he9;
    localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
    localparam logic [7:0] OP_QPAGE_WRITE  = 8'h32;
    localparam logic [7:0] OP_SECTOR_CLEAR = 8'h20;
    localparam logic [7:0] OP_HALF_CLEAR   = 8'h52;
    localparam logic [7:0] OP_BLOCK_CLEAR  = 8'hd8;

    // identity bytes, values arbitrary
    localparam logic [7:0] MFR_CODE_BYTE   = 8'h5e;
    localparam logic [7:0] PART_CODE_BYTE  = 8'h3a;
    localparam logic [7:0] MEM_TYPE_BYTE   = 8'h61;
    localparam logic [7:0] MEM_CAP_BYTE    = 8'h1a;

    // status register 1 fields
    localparam int SR1_BUSY_POS  = 0;
    localparam int SR1_WL_POS    = 1;
    localparam int SR1_BP_LO_POS = 2;
    localparam int SR1_TB_POS    = 6;
    // status register 2 fields
    localparam int SR2_CMP_POS   = 6;
    localparam logic [7:0] SR_RESET_VALUE = 8'h00;

    // frame byte counts
    localparam logic [5:0] BYTES_ADDR3      = 6'h03;
    localparam logic [5:0] BYTES_ADDR4      = 6'h04;
    localparam logic [5:0] BYTES_PAGE_MIN   = 6'h04;
    localparam logic [5:0] BYTES_WAKE_DUMMY = 6'h03;
    localparam logic [5:0] BYTES_MFR_SEL    = 6'h03;
    localparam logic [5:0] BYTES_PARAM_HDR  = 6'h04;
    localparam logic [5:0] BYTES_SAT        = 6'h3f;
    localparam logic [2:0] BIT_LAST         = 3'h7;
    localparam logic [1:0] QUAD_LEAVE_CLKS  = 2'h2;
    localparam int ADDR_W = 32;
    localparam int BLOCK_LSB = 16;

    // command outcome passed from link to system domain
    typedef struct packed {
        logic [7:0]        opcode;
        logic [5:0]        nbytes;
        logic              aligned;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        d0;
        logic [7:0]        d1;
        logic [7:0]        d2;
    } frame_t;

    // array request issued to the core
    typedef struct packed {
        logic              valid;
        logic [1:0]        kind;
        logic [ADDR_W-1:0] addr;
    } array_req_t;

    localparam logic [1:0] KIND_PAGE   = 2'h0;
    localparam logic [1:0] KIND_SECTOR = 2'h1;
    localparam logic [1:0] KIND_HALF   = 2'h2;
    localparam logic [1:0] KIND_BLOCK  = 2'h3;

endpackage : flash_cmd_pkg

/* File: verif/flash_cmd_front_end_tb_top.sv */
// self-checking bench for the flash command front end
// assumes host model drives the link; core side driven here
`timescale 1ns/1ns
module flash_cmd_front_end_tb_top;
    import flash_cmd_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       core_busy = 1'b0;
    logic [7:0] param_byte = 8'h00;
    logic       link_clk, sel_n, data_in, data_out, data_out_en;
    logic       quad_mode, addr4_mode, sleeping;
    logic [7:0] status1, status2, status3, ext_addr;
    array_req_t array_req, last_req;
    int         num_errors = 0;
    int         n_compared = 0;
    int         n_req = 0;
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (array_req.valid === 1'b1) begin
        n_req++;
        last_req = array_req;
    end
    flash_cmd_front_end flash_cmd_front_end_inst (.sys_clk(sys_clk), .rst(rst),
        .link_clk(link_clk), .sel_n(sel_n), .data_in(data_in), .data_out(data_out),
        .data_out_en(data_out_en), .core_busy(core_busy), .param_byte(param_byte),
        .array_req(array_req), .quad_mode(quad_mode), .addr4_mode(addr4_mode),
        .sleeping(sleeping), .status1(status1), .status2(status2), .status3(status3),
        .ext_addr(ext_addr));
    spi_host_model spi_host_model_inst (.link_clk(link_clk), .sel_n(sel_n),
        .data_in(data_in), .data_out(data_out), .data_out_en(data_out_en));
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // offset start keeps link edges apart from rising sys_clk edges
    task automatic xf(input int n, input logic [63:0] tx);
        #7 spi_host_model_inst.frame(n, tx);
        repeat (6) @(posedge sys_clk);
    endtask : xf
    task automatic t_latch();
        xf(8, OP_WL_SET);
        chk("latch set", 1'b1, status1[1]);
        xf(9, {OP_WL_CLEAR, 1'b0});
        chk("latch odd count", 1'b1, status1[1]);
        xf(8, OP_WL_CLEAR);
        chk("latch clear", 1'b0, status1[1]);
    endtask : t_latch
    task automatic t_status();
        xf(8, OP_WL_SET);
        xf(32, {OP_SR_WRITE, 8'h00, 8'h40, 8'h5a});
        chk("sr write", {8'h40, 8'h5a, 1'b0}, {status2, status3, status1[1]});
        xf(24, {OP_SR2_READ_B, 16'h0});
        chk("sr2 stream", 16'h4040, spi_host_model_inst.rx[15:0]);
        xf(24, {OP_SR3_READ_A, 16'h0});
        chk("sr3 stream", 16'h5a5a, spi_host_model_inst.rx[15:0]);
        xf(8, OP_WL_SET);
        xf(40, {OP_PAGE_WRITE, 24'h000100, 8'ha5});
        chk("protected program", 0, n_req);
        xf(8, OP_RESET_ARM);
        xf(8, OP_WL_SET);
        xf(8, OP_RESET);
        chk("reset cancelled", 8'h40, status2);
        xf(8, OP_RESET_ARM);
        xf(8, OP_RESET);
        chk("reset done", SR_RESET_VALUE, status2);
        xf(8, OP_VOL_WL_SET);
        xf(16, {OP_SR_WRITE, 8'h0c});
        chk("volatile write", 8'h0c, status1);
        xf(8, OP_VOL_WL_SET);
        xf(8, OP_WL_CLEAR);
        xf(16, {OP_SR_WRITE, 8'h00});
        chk("volatile lapsed", 8'h0c, status1);
        xf(8, OP_WL_SET);
        xf(16, {OP_SR2_WRITE, 8'h02});
        xf(8, OP_WL_SET);
        xf(16, {OP_SR3_WRITE_B, 8'h21});
        chk("single writes", 16'h0221, {status2, status3});
    endtask : t_status
    task automatic t_array();
        xf(8, OP_WL_SET);
        xf(32, {OP_PAGE_WRITE, 24'h000100});
        chk("short program", 0, n_req);
        xf(36, {OP_PAGE_WRITE, 24'h000100, 4'h5});
        chk("partial program", {32'h0, 1'b1}, {n_req, status1[1]});
        @(posedge sys_clk) core_busy <= 1'b1;
        xf(40, {OP_PAGE_WRITE, 24'h000100, 8'ha5});
        chk("busy program", 0, n_req);
        @(posedge sys_clk) core_busy <= 1'b0;
        xf(8, OP_WL_SET);
        xf(40, {OP_SECTOR_CLEAR, 32'h00002000});
        chk("long erase", 0, n_req);
        xf(40, {OP_PAGE_WRITE, 24'h000100, 8'ha5});
        chk("program", {8'h1, KIND_PAGE, 32'h100, 1'b0},
            {8'(n_req), last_req.kind, last_req.addr, status1[1]});
        xf(8, OP_WL_SET);
        xf(32, {OP_SECTOR_CLEAR, 24'h003000});
        chk("erase", {8'h2, KIND_SECTOR, 32'h3000}, {8'(n_req), last_req.kind, last_req.addr});
        chk("three byte mode", 1'b0, addr4_mode);
        xf(8, OP_ADDR4_ENTER);
        chk("four byte mode", 1'b1, addr4_mode);
        xf(8, OP_WL_SET);
        xf(32, {OP_HALF_CLEAR, 24'h008000});
        chk("short half erase", 2, n_req);
        xf(40, {OP_BLOCK_CLEAR, 32'h00010000});
        chk("block", {8'h3, KIND_BLOCK, 32'h10000}, {8'(n_req), last_req.kind, last_req.addr});
        xf(8, OP_ADDR4_LEAVE);
        chk("mode left", 1'b0, addr4_mode);
    endtask : t_array
    task automatic t_ident();
        @(posedge sys_clk) param_byte <= 8'hc3;
        xf(32, {OP_JEDEC_ID, 24'h0});
        chk("jedec", {MFR_CODE_BYTE, MEM_TYPE_BYTE, MEM_CAP_BYTE},
            spi_host_model_inst.rx[23:0]);
        xf(48, {OP_MFR_ID_A, 16'h0, 8'h01, 16'h0});
        chk("id part first", {PART_CODE_BYTE, MFR_CODE_BYTE}, spi_host_model_inst.rx[15:0]);
        xf(48, {OP_MFR_ID_C, 16'h0, 8'h00, 16'h0});
        chk("id mfr first", {MFR_CODE_BYTE, PART_CODE_BYTE}, spi_host_model_inst.rx[15:0]);
        xf(48, {OP_PARAM_READ, 40'h0});
        chk("param", 8'hc3, spi_host_model_inst.rx[7:0]);
        xf(8, OP_WL_SET);
        xf(16, {OP_XADDR_WRITE, 8'h03});
        xf(16, {OP_XADDR_READ, 8'h0});
        chk("ext addr", 16'h0303, {ext_addr, spi_host_model_inst.rx[7:0]});
    endtask : t_ident
    task automatic t_sleep();
        xf(8, OP_SLEEP);
        xf(16, {OP_XADDR_WRITE, 8'h07});
        xf(24, {OP_WAKE_ID, 16'h0});
        chk("asleep", {1'b1, 8'h03}, {sleeping, ext_addr});
        xf(48, {OP_WAKE_ID, 40'h0});
        chk("wake id", {1'b0, PART_CODE_BYTE, PART_CODE_BYTE},
            {sleeping, spi_host_model_inst.rx[15:0]});
        xf(8, OP_QUAD_ENTER);
        chk("quad", 1'b1, quad_mode);
        xf(8, OP_QUAD_LEAVE);
        chk("quad left", 1'b0, quad_mode);
    endtask : t_sleep
    task automatic final_report();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_latch();
        t_status();
        t_array();
        t_ident();
        t_sleep();
        final_report();
    end
    initial begin
        #3000000;
        num_errors++;
        final_report();
    end
endmodule : flash_cmd_front_end_tb_top

/* File: verif/flash_cmd_sva.sv */
// checker for the flash command front end, sys_clk domain
// assumes bind to flash_cmd_front_end; link logic seen only at its outputs
`timescale 1ns/1ns
module flash_cmd_sva (
    // system
    input wire logic                     sys_clk,
    input wire logic                     rst,
    // link and core
    input wire logic                     sel_n,
    input wire logic                     data_out_en,
    input wire flash_cmd_pkg::array_req_t array_req,
    input wire logic                     quad_mode,
    input wire logic                     addr4_mode,
    input wire logic                     sleeping,
    input wire logic [7:0]               status1,
    input wire logic [7:0]               status2,
    input wire logic [7:0]               ext_addr
);
    import flash_cmd_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_REQ_DESELECTED: assert property (array_req.valid |-> sel_n)
        else $error("array request while selected");
    AST_REQ_PULSE: assert property (array_req.valid |=> !array_req.valid)
        else $error("array request longer than one cycle");
    AST_REQ_LATCH: assert property (array_req.valid |-> $past(status1[1]))
        else $error("array request without write latch");
    AST_REQ_IDLE: assert property (array_req.valid |-> !$past(status1[0]))
        else $error("array request while core busy");
    AST_SLEEP_HOLD: assert property (sleeping && $past(sleeping) |->
        $stable(status2) && $stable(ext_addr) && !array_req.valid)
        else $error("state changed while asleep");
    AST_OUT_SELECTED: assert property (data_out_en |-> !sel_n)
        else $error("output driven while deselected");
    AST_ADDR_MODE: assert property ($changed(addr4_mode) || $changed(ext_addr) |-> sel_n)
        else $error("address mode changed mid frame");
    AST_QUAD_MODE: assert property ($changed(quad_mode) |-> sel_n && !sleeping)
        else $error("quad mode changed mid frame or asleep");
    AST_SR2_WRITE: assert property ($changed(status2) |-> sel_n ##1 sel_n)
        else $error("status 2 changed mid frame");
endmodule : flash_cmd_sva
bind flash_cmd_front_end flash_cmd_sva flash_cmd_sva_inst (.sys_clk(sys_clk), .rst(rst),
    .sel_n(sel_n), .data_out_en(data_out_en), .array_req(array_req), .quad_mode(quad_mode),
    .addr4_mode(addr4_mode), .sleeping(sleeping), .status1(status1), .status2(status2),
    .ext_addr(ext_addr));

/* File: verif/spi_host_model.sv */
// host serial master: drives select, clock and data, captures replies
// assumes clock parked low between frames, 12 ns period inside frames
`timescale 1ns/1ns
module spi_host_model (
    // link to device
    output logic      link_clk,
    output logic      sel_n,
    output logic      data_in,
    // device replies
    input wire logic  data_out,
    input wire logic  data_out_en
);
    logic [63:0] rx;
    initial begin
        link_clk = 1'b0;
        sel_n = 1'b0;
        data_in = 1'b0;
        rx = 64'h0;
        // raised after time zero so the select reset is surely seen
        #1 sel_n = 1'b1;
    end
    task automatic frame(input int n, input logic [63:0] tx);
        sel_n = 1'b0;
        #6;
        for (int i = n - 1; i >= 0; i--) begin
            data_in = tx[i];
            // undriven output reads unknown; sampled before the rise
            #6 rx = {rx[62:0], (data_out_en === 1'b1) ? data_out : 1'bx};
            link_clk = 1'b1;
            #6 link_clk = 1'b0;
        end
        #6 sel_n = 1'b1;
        // stale level flipped, never left looking valid
        data_in = ~data_in;
    endtask : frame
endmodule : spi_host_model
